// >>> design/xmem_pkg.sv
/*
  Constants shared by the expanded memory mapper and its DRAM address
  multiplexer: timing, widths, register indices, field positions, decodes.
  Assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package xmem_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int ROW_HOLD_NS = 80;
  localparam int ROW_CYC = (ROW_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // memory geometry
  // ****************************************
  localparam int MUX_W = 9;
  localparam int PAGE_W = 7;
  localparam int NUM_BANKS = 3;
  localparam int STD_PAGES = 24;
  localparam int NUM_WIN_PAGES = 4;
  localparam int PG_EN_BIT = 7;
  localparam logic [5:0] WIN_LO = 6'h31;
  localparam logic [5:0] WIN_HI = 6'h3B;
  localparam logic [5:0] WBASE_RST = 6'h34;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam int IDX_LSB = 2;
  localparam logic [9:0] IDX_PORT = 10'h0EE;
  localparam logic [9:0] DATA_PORT = 10'h0EF;
  localparam logic [9:0] WBASE_IDX = 10'h000;
  localparam logic [9:0] MISC_IDX = 10'h001;
  localparam logic [7:0] CFG0_SEL = 8'h50;
  localparam logic [7:0] CFG1_SEL = 8'h51;
  localparam logic [3:0] UNIT_ID = 4'h3;  // arbitrary value
  localparam logic [2:0] BLOCK_CODE = 3'h7;
  localparam int MISC_PSU_TX = 0;
  localparam int MISC_DISP_OFF = 1;
  localparam int MISC_PSU_RX = 8;
  localparam int MISC_IN_REF = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // i/o decode: port group 2X8H..2XFH and peripherals
  // ****************************************
  localparam logic [1:0] GRP_TOP = 2'h2;
  localparam int GRP_HI_BIT = 3;
  localparam int PAGE_SEL_BIT = 2;
  localparam logic [9:0] RTC_BASE = 10'h070;
  localparam logic [9:0] RTC_MASK = 10'h3F0;
  localparam logic [9:0] SER_BASE = 10'h3F8;
  localparam logic [9:0] PRT_BASE = 10'h378;
  localparam logic [9:0] FDD_BASE = 10'h3F0;
  localparam logic [9:0] OCT_MASK = 10'h3F8;
  localparam logic [9:0] HDD_BASE = 10'h320;
  localparam logic [9:0] HDD_MASK = 10'h3F0;

endpackage

// >>> design/dram_addr_mux.sv
/*
  Row/column multiplexer for the expansion DRAM: shows the row, holds it
  for the row time, then switches to the column and lowers the column strobe.
  Assumes start is a same-clock level that stays high for the whole access.
*/
`timescale 1ns/10ps
module dram_addr_mux #(
  parameter int ROW_CYC = xmem_pkg::ROW_CYC,
  parameter int AW = xmem_pkg::MUX_W
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // access request
  input wire logic start,
  input wire logic [AW-1:0] row_addr,
  input wire logic [AW-1:0] col_addr,
  // dram side
  output logic [AW-1:0] dram_mux_addr,
  output logic cas_n
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ROW = 3'h2,
    ST_COL = 3'h4
  } mux_state_t;

  localparam int CW = $clog2(ROW_CYC + 1);

  mux_state_t state_reg;
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      cas_n <= 1'b1;
      dram_mux_addr <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          dram_mux_addr <= row_addr;
          if (start) begin
            state_reg <= ST_ROW;
            cnt_reg <= CW'(1);
          end
        end
        ST_ROW: begin
          if (!start) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == CW'(ROW_CYC)) begin
            state_reg <= ST_COL;
            dram_mux_addr <= col_addr;
            cas_n <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + CW'(1);
          end
        end
        ST_COL: begin
          if (!start) begin
            state_reg <= ST_IDLE;
            cas_n <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cas_n <= 1'b1;
        end
      endcase
    end
  end

  sequence s_open;
    start && state_reg == ST_IDLE;
  endsequence

  AST_CAS_AFTER_ROW: assert property (@(posedge aclk) disable iff (!aresetn)
    s_open ##1 start [*3] |-> !cas_n)
    else $error("column strobe late after row phase");

  AST_CAS_NOT_EARLY: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(cas_n) |-> $past(state_reg == ST_ROW) && dram_mux_addr == $past(col_addr))
    else $error("column strobe without row phase or column address");

endmodule // dram_addr_mux

// >>> design/expanded_memory_mapper.sv
/*
  Expanded memory mapper: window decode, page registers, DRAM strobes,
  refresh, peripheral selects and the configuration registers on AXI4-Lite.
  Assumes system bus pins are asynchronous to aclk and are synchronised here.
*/
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module expanded_memory_mapper #(
  parameter int NB = xmem_pkg::NUM_BANKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system bus
  input wire logic [19:0] sys_addr,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic aen,
  output logic [7:0] sys_data_o,
  output logic sys_data_oe,
  // memory timing and refresh
  input wire logic row_strobe_time_odd_n,
  input wire logic row_strobe_time_even_n,
  input wire logic refresh_begin,
  input wire logic refresh_finish,
  input wire logic dack0_n,
  // dram
  output logic [NB-1:0] ras_hi_n,
  output logic [NB-1:0] ras_lo_n,
  output logic cas_n,
  output logic [xmem_pkg::MUX_W-1:0] dram_mux_addr,
  // selects
  output logic xmem_select_n,
  output logic clock_chip_sel_n,
  output logic clock_chip_rd_n,
  output logic clock_chip_wr_n,
  output logic serial_port_sel_n,
  output logic printer_sel_n,
  output logic floppy_sel_n,
  output logic disk_sel_n,
  // display and power supply
  output logic display_array_off,
  output logic psu_serial_out,
  input wire logic psu_serial_in
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  localparam int SW = 29;
  localparam logic [SW-1:0] SYNC_RST = {20'h0_0000, 9'h1B2};

  logic [SW-1:0] meta_reg;
  logic [SW-1:0] sync_reg;
  logic [19:0] sa;
  logic ior_s, iow_s, aen_s, odd_n_s, even_n_s, rbeg_s, rfin_s, dack_n_s, psu_rx_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
    end else begin
      meta_reg <= {sys_addr, ior_n, iow_n, aen, row_strobe_time_odd_n,
        row_strobe_time_even_n, refresh_begin, refresh_finish, dack0_n, psu_serial_in};
      sync_reg <= meta_reg;
    end
  end

  assign {sa, ior_s, iow_s, aen_s, odd_n_s, even_n_s, rbeg_s, rfin_s, dack_n_s,
    psu_rx_s} = sync_reg;

  // ****************************************
  // registers and decode helpers
  // ****************************************
  logic [7:0] index_reg;
  logic [3:0] cfg_port_reg;
  logic [4:0] hram_reg;
  logic [5:0] wbase_reg;
  logic psu_tx_reg;
  logic [7:0] page_reg [xmem_pkg::NUM_WIN_PAGES];
  logic blocked;
  logic in_refresh_reg;

  assign blocked = cfg_port_reg[2:0] == xmem_pkg::BLOCK_CODE;

  // only this unit's own group is decoded, so units on other groups coexist
  function automatic logic grp_hit(input logic [9:0] a, input logic [3:0] port);
    return a[9:8] == xmem_pkg::GRP_TOP && a[7:4] == port
      && a[xmem_pkg::GRP_HI_BIT];
  endfunction

  function automatic logic io_at(input logic [9:0] a, input logic [9:0] b,
      input logic [9:0] m);
    return (a & m) == b;
  endfunction

  function automatic logic mapped(input logic [9:0] i);
    return i == xmem_pkg::IDX_PORT || i == xmem_pkg::DATA_PORT
      || i == xmem_pkg::WBASE_IDX || i == xmem_pkg::MISC_IDX
      || (grp_hit(i, cfg_port_reg) && !blocked);
  endfunction

  function automatic logic [31:0] rd_val(input logic [9:0] i);
    logic [31:0] v;
    v = '0;
    if (i == xmem_pkg::DATA_PORT && index_reg == xmem_pkg::CFG0_SEL) begin
      v[7:0] = {xmem_pkg::UNIT_ID, cfg_port_reg};
    end else if (i == xmem_pkg::DATA_PORT && index_reg == xmem_pkg::CFG1_SEL) begin
      v[4:0] = hram_reg;
    end else if (i == xmem_pkg::WBASE_IDX) begin
      v[5:0] = wbase_reg;
    end else if (i == xmem_pkg::MISC_IDX) begin
      v[xmem_pkg::MISC_PSU_TX] = psu_tx_reg;
      v[xmem_pkg::MISC_DISP_OFF] = display_array_off;
      v[xmem_pkg::MISC_PSU_RX] = psu_rx_s;
      v[xmem_pkg::MISC_IN_REF] = in_refresh_reg;
    end else if (grp_hit(i, cfg_port_reg) && !i[xmem_pkg::PAGE_SEL_BIT]) begin
      v[7:0] = page_reg[i[1:0]];
    end
    return v;
  endfunction

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic aw_full_reg, w_full_reg, w_lane_reg, do_wr;
  logic [9:0] aw_idx_reg;
  logic [7:0] w_data_reg;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_data_reg <= '0;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= xmem_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[11:xmem_pkg::IDX_LSB];
      end else if (do_wr) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_full_reg <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_idx_reg) ? xmem_pkg::RESP_OKAY : xmem_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  logic wr_en;
  assign wr_en = do_wr && w_lane_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      index_reg <= '0;
      cfg_port_reg <= '0;
      hram_reg <= '0;
      wbase_reg <= xmem_pkg::WBASE_RST;
      psu_tx_reg <= 1'b0;
      display_array_off <= 1'b0;
      for (int k = 0; k < xmem_pkg::NUM_WIN_PAGES; k++) begin
        page_reg[k] <= '0;
      end
    end else if (wr_en) begin
      if (aw_idx_reg == xmem_pkg::IDX_PORT) begin
        index_reg <= w_data_reg;
      end
      if (aw_idx_reg == xmem_pkg::DATA_PORT && index_reg == xmem_pkg::CFG0_SEL) begin
        cfg_port_reg <= w_data_reg[3:0];
      end
      if (aw_idx_reg == xmem_pkg::DATA_PORT && index_reg == xmem_pkg::CFG1_SEL) begin
        hram_reg <= w_data_reg[4:0];
      end
      if (aw_idx_reg == xmem_pkg::WBASE_IDX) begin
        wbase_reg <= w_data_reg[5:0];
      end
      if (aw_idx_reg == xmem_pkg::MISC_IDX) begin
        psu_tx_reg <= w_data_reg[xmem_pkg::MISC_PSU_TX];
        display_array_off <= w_data_reg[xmem_pkg::MISC_DISP_OFF];
      end
      if (grp_hit(aw_idx_reg, cfg_port_reg) && !blocked
          && !aw_idx_reg[xmem_pkg::PAGE_SEL_BIT]) begin
        page_reg[aw_idx_reg[1:0]] <= w_data_reg;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= xmem_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val(s_axi_araddr[11:xmem_pkg::IDX_LSB]);
      s_axi_rresp <= mapped(s_axi_araddr[11:xmem_pkg::IDX_LSB]) ? xmem_pkg::RESP_OKAY
        : xmem_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // window decode
  // ****************************************
  logic [5:0] blk, base_end;
  logic [1:0] slot, bank;
  logic [7:0] page_ent;
  logic in_win, win_hit, refreshing;
  logic [19:0] word_addr;

  always_comb begin
    blk = sa[19:14];
    base_end = wbase_reg + 6'(xmem_pkg::NUM_WIN_PAGES - 1);
    // window must sit wholly in upper memory or it is not decoded
    in_win = wbase_reg >= xmem_pkg::WIN_LO && base_end <= xmem_pkg::WIN_HI
      && blk >= wbase_reg && blk <= base_end;
    slot = 2'(blk - wbase_reg);
    page_ent = page_reg[slot];
    win_hit = in_win && !aen_s && !blocked && page_ent[xmem_pkg::PG_EN_BIT]
      && page_ent[xmem_pkg::PAGE_W-1:0] < 7'(xmem_pkg::STD_PAGES);
    word_addr = {page_ent[xmem_pkg::PAGE_W-1:0], sa[13:1]};
    bank = word_addr[19:18];
  end

  // ****************************************
  // refresh
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_refresh_reg <= 1'b0;
    end else if (rbeg_s) begin
      in_refresh_reg <= 1'b1;
    end else if (rfin_s) begin
      in_refresh_reg <= 1'b0;
    end
  end

  assign refreshing = in_refresh_reg || !dack_n_s;

  // ****************************************
  // dram strobes and address
  // ****************************************
  // refresh strobes every bank together; no column strobe then
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hi_n_reg, lo_n_reg, use_bank;
    assign use_bank = refreshing || (win_hit && bank == 2'(b));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hi_n_reg <= 1'b1;
        lo_n_reg <= 1'b1;
      end else begin
        hi_n_reg <= !(use_bank && !odd_n_s);
        lo_n_reg <= !(use_bank && !even_n_s);
      end
    end
    assign ras_hi_n[b] = hi_n_reg;
    assign ras_lo_n[b] = lo_n_reg;
  end

  dram_addr_mux u_mux (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(win_hit && !refreshing && (!odd_n_s || !even_n_s)),
    .row_addr(refreshing ? sa[8:0] : word_addr[8:0]),
    .col_addr(word_addr[17:9]),
    .dram_mux_addr(dram_mux_addr),
    .cas_n(cas_n)
  );

  // ****************************************
  // selects, i/o read data, power supply line
  // ****************************************
  logic io_cyc, io_rd;
  assign io_cyc = !aen_s;
  assign io_rd = io_cyc && !ior_s && grp_hit(sa[9:0], cfg_port_reg) && !blocked;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xmem_select_n <= 1'b1;
      clock_chip_sel_n <= 1'b1;
      clock_chip_rd_n <= 1'b1;
      clock_chip_wr_n <= 1'b1;
      serial_port_sel_n <= 1'b1;
      printer_sel_n <= 1'b1;
      floppy_sel_n <= 1'b1;
      disk_sel_n <= 1'b1;
      sys_data_oe <= 1'b0;
      sys_data_o <= '0;
      psu_serial_out <= 1'b1;
    end else begin
      xmem_select_n <= !win_hit;
      clock_chip_sel_n <= !(io_cyc && io_at(sa[9:0], xmem_pkg::RTC_BASE,
        xmem_pkg::RTC_MASK));
      clock_chip_rd_n <= !(io_cyc && !ior_s && io_at(sa[9:0], xmem_pkg::RTC_BASE,
        xmem_pkg::RTC_MASK));
      clock_chip_wr_n <= !(io_cyc && !iow_s && io_at(sa[9:0], xmem_pkg::RTC_BASE,
        xmem_pkg::RTC_MASK));
      serial_port_sel_n <= !(io_cyc && io_at(sa[9:0], xmem_pkg::SER_BASE,
        xmem_pkg::OCT_MASK));
      printer_sel_n <= !(io_cyc && io_at(sa[9:0], xmem_pkg::PRT_BASE, xmem_pkg::OCT_MASK));
      floppy_sel_n <= !(io_cyc && io_at(sa[9:0], xmem_pkg::FDD_BASE, xmem_pkg::OCT_MASK));
      disk_sel_n <= !(io_cyc && io_at(sa[9:0], xmem_pkg::HDD_BASE, xmem_pkg::HDD_MASK));
      sys_data_oe <= io_rd;
      sys_data_o <= (io_rd && !sa[xmem_pkg::PAGE_SEL_BIT]) ? page_reg[sa[1:0]] : 8'h00;
      psu_serial_out <= !psu_tx_reg;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_BLOCK_NO_SEL: assert property (blocked |=> xmem_select_n)
    else $error("select while expansion memory blocked");

  AST_DATA_ONLY_IOR: assert property (sys_data_oe |-> $past(!ior_s))
    else $error("data driven without i/o read");

  AST_PSU_INV: assert property (##1 psu_serial_out != $past(psu_tx_reg))
    else $error("power supply data not inverted");

  AST_CFG_CLEAR: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> cfg_port_reg == 4'h0 && hram_reg == 5'h00)
    else $error("configuration not cleared");

  AST_REFRESH_END: assert property (rfin_s && !rbeg_s |=> !in_refresh_reg)
    else $error("refresh not ended by finish");

  AST_RAS_STEER: assert property ((ras_hi_n != '1) |-> $past(!odd_n_s))
    else $error("high bank strobe without odd timing");

  AST_RAS_STEER_LO: assert property ((ras_lo_n != '1) |-> $past(!even_n_s))
    else $error("low bank strobe without even timing");

  AST_SEL_IN_WINDOW: assert property (!xmem_select_n |->
    $past(sa[19:14]) >= xmem_pkg::WIN_LO && $past(sa[19:14]) <= xmem_pkg::WIN_HI)
    else $error("select outside upper memory");

  AST_CLK_RD_SEL: assert property (!clock_chip_rd_n |-> !clock_chip_sel_n)
    else $error("clock chip read without select");

  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

endmodule // expanded_memory_mapper

// >>> dv/dram_bank_model.sv
/*
  Expansion DRAM bank model: latches the row and column seen on the
  multiplexed address at the strobe edges. Assumes active-low strobes.
*/
`timescale 1ns/10ps
module dram_bank_model (
  // dram pins
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic [8:0] mux_addr,
  // captured addresses
  output logic [8:0] row_seen,
  output logic [8:0] col_seen
);
  // ****************************************
  // capture
  // ****************************************
  initial begin
    row_seen = 9'h000;
    col_seen = 9'h000;
  end
  always @(negedge ras_n) row_seen = mux_addr;
  always @(negedge cas_n) col_seen = mux_addr;
endmodule // dram_bank_model

// >>> dv/tb_top.sv
/*
  Testbench for the expanded memory mapper: AXI4-Lite register traffic,
  system bus decode, DRAM strobes and refresh. Assumes NB of 3 banks.
*/
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, ior_n, iow_n, aen, sys_data_oe, refresh_begin, refresh_finish;
  logic row_strobe_time_odd_n, row_strobe_time_even_n, dack0_n, cas_n, xmem_select_n;
  logic clock_chip_sel_n, clock_chip_rd_n, clock_chip_wr_n, serial_port_sel_n;
  logic printer_sel_n, floppy_sel_n, disk_sel_n, display_array_off;
  logic psu_serial_out, psu_serial_in;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [19:0] sys_addr;
  logic [7:0] sys_data_o;
  logic [2:0] ras_hi_n, ras_lo_n;
  logic [8:0] dram_mux_addr, row_seen, col_seen;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int n_fail, check_count, i;

  expanded_memory_mapper u_expanded_memory_mapper (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sys_addr(sys_addr), .ior_n(ior_n), .iow_n(iow_n), .aen(aen), .sys_data_o(sys_data_o),
    .sys_data_oe(sys_data_oe), .row_strobe_time_odd_n(row_strobe_time_odd_n),
    .row_strobe_time_even_n(row_strobe_time_even_n), .refresh_begin(refresh_begin),
    .refresh_finish(refresh_finish), .dack0_n(dack0_n), .ras_hi_n(ras_hi_n),
    .ras_lo_n(ras_lo_n), .cas_n(cas_n), .dram_mux_addr(dram_mux_addr),
    .xmem_select_n(xmem_select_n), .clock_chip_sel_n(clock_chip_sel_n),
    .clock_chip_rd_n(clock_chip_rd_n), .clock_chip_wr_n(clock_chip_wr_n),
    .serial_port_sel_n(serial_port_sel_n), .printer_sel_n(printer_sel_n),
    .floppy_sel_n(floppy_sel_n), .disk_sel_n(disk_sel_n),
    .display_array_off(display_array_off), .psu_serial_out(psu_serial_out),
    .psu_serial_in(psu_serial_in));
  dram_bank_model u_dram_bank_model (.ras_n(ras_lo_n[0]), .cas_n(cas_n),
    .mux_addr(dram_mux_addr), .row_seen(row_seen), .col_seen(col_seen));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // master releases each channel as soon as it is taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back({32'h0, r});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("bresp", bq.pop_front(), {32'h0, s_axi_bresp});
  end

  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
    {s_axi_rready, aen, refresh_begin, refresh_finish, psu_serial_in} = 5'h00;
    {ior_n, iow_n, row_strobe_time_odd_n, row_strobe_time_even_n, dack0_n} = 5'h1F;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    sys_addr = 20'h00000;
    seed = 32'hDD596475;
    cyc(2);
    aresetn <= 1'b1;
    chk("psu_out", 34'h1, {33'h0, psu_serial_out});
    axr(12'h000, 34'h34);
    axw(12'h3B8, 32'h50, 2'h0);
    axr(12'h3BC, 34'h30);
    axw(12'h3B8, 32'h51, 2'h0);
    axr(12'h3BC, 34'h00);
    seed = lfsr(seed);
    axw(12'h3BC, seed, 2'h0);
    axr(12'h3BC, {29'h0, seed[4:0]});
    axw(12'h3B8, 32'h50, 2'h0);
    axw(12'h3BC, 32'hF0, 2'h0);
    axr(12'h3BC, 34'h30);
    axr(12'h100, {xmem_pkg::RESP_SLVERR, 32'h0});
    $display("test config done");
    axw(12'h820, 32'h81, 2'h0);
    axr(12'h820, 34'h81);
    sys_addr <= 20'h00208;
    ior_n <= 1'b0;
    cyc(5);
    chk("data_oe", 34'h1, {33'h0, sys_data_oe});
    chk("data_o", 34'h81, {26'h0, sys_data_o});
    ior_n <= 1'b1;
    cyc(5);
    chk("data_oe", 34'h0, {33'h0, sys_data_oe});
    $display("test io read done");
    for (i = 0; i < 2; i++) begin
      sys_addr <= 20'hD02A4 | 20'(i);
      cyc(5);
      chk("xmem_sel", 34'h0, {33'h0, xmem_select_n});
      {row_strobe_time_odd_n, row_strobe_time_even_n} <= (i == 1) ? 2'b01 : 2'b10;
      cyc(7);
      chk("ras_hi", (i == 1) ? 34'h6 : 34'h7, {31'h0, ras_hi_n});
      chk("ras_lo", (i == 1) ? 34'h7 : 34'h6, {31'h0, ras_lo_n});
      chk("cas", 34'h0, {33'h0, cas_n});
      {row_strobe_time_odd_n, row_strobe_time_even_n} <= 2'b11;
      cyc(5);
    end
    chk("row", 34'h152, {25'h0, row_seen});
    chk("col", 34'h010, {25'h0, col_seen});
    axw(12'h3BC, 32'h0F, 2'h0);
    cyc(5);
    chk("xmem_sel", 34'h1, {33'h0, xmem_select_n});
    axw(12'h3BC, 32'h00, 2'h0);
    axw(12'h3BC, 32'h01, 2'h0);
    axr(12'h860, 34'h81);
    axr(12'h820, {xmem_pkg::RESP_SLVERR, 32'h0});
    axw(12'h3BC, 32'h00, 2'h0);
    axw(12'h820, 32'h97, 2'h0);
    cyc(5);
    chk("xmem_sel", 34'h0, {33'h0, xmem_select_n});
    axw(12'h820, 32'h98, 2'h0);
    cyc(5);
    chk("xmem_sel", 34'h1, {33'h0, xmem_select_n});
    $display("test window done");
    sys_addr <= 20'h00000;
    refresh_begin <= 1'b1;
    {row_strobe_time_odd_n, row_strobe_time_even_n} <= 2'b00;
    cyc(6);
    chk("ras_ref", 34'h0, {28'h0, ras_hi_n, ras_lo_n});
    chk("cas_ref", 34'h1, {33'h0, cas_n});
    refresh_begin <= 1'b0;
    refresh_finish <= 1'b1;
    cyc(5);
    chk("ras_end", 34'h3F, {28'h0, ras_hi_n, ras_lo_n});
    dack0_n <= 1'b0;
    cyc(5);
    chk("ras_dack", 34'h0, {28'h0, ras_hi_n, ras_lo_n});
    {refresh_finish, row_strobe_time_odd_n, row_strobe_time_even_n} <= 3'b011;
    dack0_n <= 1'b1;
    psu_serial_in <= 1'b1;
    axw(12'h004, 32'h3, 2'h0);
    cyc(5);
    chk("disp_off", 34'h1, {33'h0, display_array_off});
    chk("psu_out", 34'h0, {33'h0, psu_serial_out});
    axr(12'h004, 34'h103);
    $display("test refresh and misc done");
    for (i = 0; i < 5; i++) begin
      sys_addr <= (i == 0) ? 20'h070 : (i == 1) ? 20'h3F8 : (i == 2) ? 20'h378 :
        (i == 3) ? 20'h3F0 : 20'h320;
      cyc(5);
      chk("selects", {29'h0, ~(5'h10 >> i)}, {29'h0, clock_chip_sel_n,
        serial_port_sel_n, printer_sel_n, floppy_sel_n, disk_sel_n});
    end
    sys_addr <= 20'h00070;
    ior_n <= 1'b0;
    cyc(5);
    chk("clk_chip_strobes", 34'h1, {32'h0, clock_chip_rd_n, clock_chip_wr_n});
    {ior_n, iow_n} <= 2'b10;
    cyc(5);
    chk("clk_chip_strobes", 34'h2, {32'h0, clock_chip_rd_n, clock_chip_wr_n});
    iow_n <= 1'b1;
    $display("test selects done");
    end_sim();
  end
endmodule // tb_top
